// [shpt_pkg.sv]
`default_nettype none
package shpt_pkg;
  // Clock of both ends.
  localparam int CLK_NS = 20;
  localparam int TW = 20;
  // Frame-select to first clock, cold and locked (least times, rounded up).
  localparam int T_SC_COLD_US = 150;
  localparam int SC_COLD_CYC = (T_SC_COLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int T_SC_WARM_NS = 2000;
  localparam int SC_WARM_CYC = (T_SC_WARM_NS + CLK_NS - 1) / CLK_NS;
  // Last clock fall to frame-select fall, write and read.
  localparam int T_WE_NS = 2000;
  localparam int WE_CYC = (T_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RE_NS = 2000;
  localparam int RE_CYC = (T_RE_NS + CLK_NS - 1) / CLK_NS;
  // Last command fall to first data rise on a read.
  localparam int T_RS_NS = 500;
  localparam int RS_CYC = (T_RS_NS + CLK_NS - 1) / CLK_NS;
  // Longest latencies the device must meet (rounded down).
  localparam int T_WS_MAX_NS = 200;
  localparam int WS_MAX_CYC = T_WS_MAX_NS / CLK_NS;
  localparam int T_RR_MAX_NS = 4000;
  localparam int RR_MAX_CYC = T_RR_MAX_NS / CLK_NS;
  // Write processing window and the chosen write time.
  localparam int T_W_MIN_MS = 6;
  localparam int W_MIN_CYC = (T_W_MIN_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int T_W_MAX_MS = 14;
  localparam int W_MAX_CYC = T_W_MAX_MS * 1000000 / CLK_NS;
  localparam int T_WRITE_MS = 10;
  localparam int WRITE_CYC_DEF = T_WRITE_MS * 1000000 / CLK_NS;
  // Measurement limit and the chosen measurement time.
  localparam int T_MT_MAX_MS = 6;
  localparam int MT_MAX_CYC = T_MT_MAX_MS * 1000000 / CLK_NS;
  localparam int T_MEAS_US = 5000;
  localparam int MEAS_CYC_DEF = T_MEAS_US * 1000 / CLK_NS;
  // Serial clock made by the host.
  localparam int T_SCLK_HALF_NS = 160;
  localparam int SCLK_HALF = T_SCLK_HALF_NS / CLK_NS;
  // Command encodings.
  localparam logic [4:0] READ_PFX = 5'h08;
  localparam logic [4:0] WRITE_PFX = 5'h0A;
  localparam logic [1:0] DIRECT_PFX = 2'h3;
  localparam logic [2:0] DC_RESET = 3'h0;
  localparam logic [2:0] DC_IOMODE = 3'h1;
  localparam logic [2:0] DC_HWID = 3'h2;
  localparam logic [2:0] DC_MEAS = 3'h6;
  localparam logic [2:0] IOM_SERIAL = 3'h1;
  localparam logic [4:0] READ_BITS = 5'h10;
  localparam logic [4:0] WRITE_BITS = 5'h18;
  localparam logic [4:0] DIRECT_BITS = 5'h08;
  // Host command kinds.
  localparam logic [1:0] KIND_READ = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_DIRECT = 2'h2;
  localparam int AW = 11;
endpackage : shpt_pkg
`default_nettype wire

// [shpt_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Four-wire link: frame select, serial clock, serial in, serial out.
interface shpt_link_if;
  logic fsel;
  logic sclk;
  logic sdi;
  logic sdo;
  modport dev (input fsel, input sclk, input sdi, output sdo);
  modport host (output fsel, output sclk, output sdi, input sdo);
endinterface : shpt_link_if
`default_nettype wire

// [shpt_device.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Host waits setup before first clock.
// - Frame-select fall launches the write.
// - Host leaves gap before write launch.
// - Write processing starts within 200 ns.
// - Locked mode: output high during write.
// - Write lasts between 6 and 14 ms.
// - Read ready raised within 4 us.
// - Host waits 500 ns and ready.
// - Host ends read after 2 us gap.
// - Measurement done raises output within 6 ms.
// - Host may clock result at once.
// - Read word 01000 plus address, incrementing.
// - Eight clocks per byte, stable at fall.
// - Direct byte: 11, index, parameter.
// - Locked: output low after write.
module shpt_device
  import shpt_pkg::*;
#(
  parameter int WRITE_CYC = WRITE_CYC_DEF,
  parameter int MEAS_CYC = MEAS_CYC_DEF,
  parameter logic [7:0] HW_ID = 8'h5A // Arbitrary identifier value.
) (
  input wire logic MCLK,
  input wire logic RESET,
  shpt_link_if.dev LINK,
  input wire logic AUX_LEVEL,
  input wire logic [15:0] MEAS_VALUE,
  output logic SERIAL_LOCKED,
  output logic WRITE_BUSY
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_CMD = 3'h1,
    DS_WRITE = 3'h3,
    DS_MEAS = 3'h2,
    DS_RESP = 3'h6
  } shpt_dst_t;

  typedef enum logic [1:0] {
    SRC_MEM = 2'h0,
    SRC_ID = 2'h1,
    SRC_MEAS = 2'h2
  } shpt_src_t;

  typedef struct packed {
    shpt_dst_t st;
    logic [2:0] fs;
    logic [2:0] ck;
    logic [1:0] di;
    logic [22:0] sh;
    logic [4:0] bits;
    logic wr_ok;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic lock;
    logic [TW-1:0] timer;
    shpt_src_t src;
    logic [1:0] idx;
    logic [2:0] rbit;
    logic [7:0] obyte;
    logic [15:0] meas;
    logic dout;
  } shpt_dev_t;

  shpt_dev_t s;
  shpt_dev_t next_s;

  // Byte store; reads and writes address it by the command address.
  logic [7:0] mem [0:(1 << AW) - 1];
  logic [7:0] rd_byte;
  logic [7:0] load_byte;
  logic [23:0] word;
  logic fs_rise;
  logic fs_fall;
  logic ck_rise;
  logic wr_commit;
  logic idle_level;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised pins.

  // The first stage of each synchroniser never feeds logic; edges compare the second and third stages.
  assign fs_rise = s.fs[1] & ~s.fs[2];
  assign fs_fall = ~s.fs[1] & s.fs[2];
  assign ck_rise = s.ck[1] & ~s.ck[2];
  // Incoming bit appended last, so the first bit ends up on top.
  assign word = {s.sh, s.di[1]};
  assign rd_byte = mem[s.addr];
  // Outside frames the line shows the non-serial level unless locked.
  assign idle_level = s.lock ? 1'b0 : AUX_LEVEL;
  assign wr_commit = (s.st == DS_WRITE) && (s.timer == TW'(WRITE_CYC - 1));

  // Byte handed to the shifter at the start of each returned byte.
  always_comb begin
    case (s.src)
      SRC_MEM: load_byte = rd_byte;
      SRC_ID: load_byte = (s.idx == 2'h0) ? HW_ID : 8'h00;
      SRC_MEAS: begin
        case (s.idx)
          2'h0: load_byte = s.meas[15:8];
          2'h1: load_byte = s.meas[7:0];
          default: load_byte = 8'h00;
        endcase
      end
      default: load_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // One pass works out the whole next state from the present one.
  always_comb begin
    next_s = s;
    next_s.fs = {s.fs[1:0], LINK.fsel};
    next_s.ck = {s.ck[1:0], LINK.sclk};
    next_s.di = {s.di[0], LINK.sdi};
    case (s.st)
      DS_IDLE: begin
        next_s.dout = idle_level;
        if (fs_rise) begin
          next_s.st = DS_CMD;
          next_s.bits = 5'h00;
          next_s.wr_ok = 1'b0;
          next_s.dout = 1'b0;
        end
      end
      DS_CMD: begin
        next_s.dout = 1'b0;
        if (fs_fall) begin
          // The write begins on the very edge that ends the frame.
          next_s.st = s.wr_ok ? DS_WRITE : DS_IDLE;
          next_s.timer = '0;
          next_s.dout = s.wr_ok ? 1'b1 : idle_level;
        end else if (ck_rise) begin
          next_s.sh = word[22:0];
          // Counting stops at the longest word, so extra clocks do no harm.
          if (s.bits != WRITE_BITS) begin
            next_s.bits = s.bits + 5'h01;
          end
          if (s.bits == DIRECT_BITS - 5'h01 && word[7:6] == DIRECT_PFX) begin
            case (word[5:3])
              DC_RESET: next_s.lock = 1'b0;
              DC_IOMODE: next_s.lock = (word[2:0] == IOM_SERIAL);
              DC_HWID: begin
                next_s.st = DS_RESP;
                next_s.src = SRC_ID;
                next_s.idx = 2'h0;
                next_s.rbit = 3'h0;
                next_s.dout = 1'b1;
              end
              DC_MEAS: begin
                next_s.st = DS_MEAS;
                next_s.timer = '0;
              end
              default: next_s.lock = s.lock;
            endcase
          end
          if (s.bits == READ_BITS - 5'h01) begin
            next_s.addr = word[AW-1:0];
            if (word[15:11] == READ_PFX) begin
              // Ready is raised as soon as the word is decoded.
              next_s.st = DS_RESP;
              next_s.src = SRC_MEM;
              next_s.rbit = 3'h0;
              next_s.dout = 1'b1;
            end
          end
          if (s.bits == WRITE_BITS - 5'h01 && word[23:19] == WRITE_PFX) begin
            next_s.wdata = word[7:0];
            next_s.wr_ok = 1'b1;
          end
        end
      end
      DS_WRITE: begin
        // Frame select is ignored until the write is over.
        next_s.dout = 1'b1;
        next_s.timer = s.timer + TW'(1);
        if (wr_commit) begin
          next_s.st = DS_IDLE;
          next_s.dout = idle_level;
        end
      end
      DS_MEAS: begin
        next_s.dout = 1'b0;
        next_s.timer = s.timer + TW'(1);
        if (fs_fall) begin
          next_s.st = DS_IDLE;
          next_s.dout = idle_level;
        end else if (s.timer == TW'(MEAS_CYC - 1)) begin
          // Result is frozen here so a late change cannot tear it.
          next_s.st = DS_RESP;
          next_s.meas = MEAS_VALUE;
          next_s.src = SRC_MEAS;
          next_s.idx = 2'h0;
          next_s.rbit = 3'h0;
          next_s.dout = 1'b1;
        end
      end
      DS_RESP: begin
        if (fs_fall) begin
          next_s.st = DS_IDLE;
          next_s.dout = idle_level;
        end else if (ck_rise) begin
          // New bit goes out after the rise and holds over the fall.
          next_s.rbit = s.rbit + 3'h1;
          if (s.rbit == 3'h0) begin
            next_s.dout = load_byte[7];
            next_s.obyte = {load_byte[6:0], 1'b0};
            next_s.addr = s.addr + AW'(1);
            if (s.idx != 2'h3) begin
              next_s.idx = s.idx + 2'h1;
            end
          end else begin
            next_s.dout = s.obyte[7];
            next_s.obyte = {s.obyte[6:0], 1'b0};
          end
        end
      end
      default: begin
        next_s.st = DS_IDLE;
        next_s.dout = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Synchronous reset clears every field, the lock included.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // The byte lands only at the end of the processing time.
  always_ff @(posedge MCLK) begin
    if (wr_commit) begin
      mem[s.addr] <= s.wdata;
    end
  end

  assign LINK.sdo = s.dout;
  assign SERIAL_LOCKED = s.lock;
  assign WRITE_BUSY = (s.st == DS_WRITE);

endmodule : shpt_device
`default_nettype wire

// [shpt_host.sv]
`timescale 1ns/1ps
`default_nettype none
module shpt_host
  import shpt_pkg::*;
#(
  parameter int SETUP_COLD_CYC = SC_COLD_CYC,
  parameter int WRITE_WAIT_CYC = W_MAX_CYC
) (
  input wire logic MCLK,
  input wire logic RESET,
  shpt_link_if.host LINK,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [1:0] CMD_KIND,
  input wire logic [AW-1:0] CMD_ADDR,
  input wire logic [7:0] CMD_WDATA,
  input wire logic [2:0] CMD_DIRECT_COMMAND_INDEX,
  input wire logic [2:0] CMD_DIRECT_COMMAND_PARAMETER,
  input wire logic [7:0] CMD_NBYTES,
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic [7:0] RX_DATA,
  output logic BUSY
);

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_SETUP = 3'h1,
    HS_SHIFT = 3'h3,
    HS_GAP = 3'h2,
    HS_RX = 3'h6,
    HS_TAIL = 3'h7,
    HS_WWAIT = 3'h5
  } shpt_hst_t;

  typedef struct packed {
    shpt_hst_t st;
    logic lock;
    logic [1:0] kind;
    logic [5:0] dc;
    logic resp;
    logic [23:0] tx;
    logic [4:0] nbits;
    logic [4:0] bits;
    logic [7:0] nbytes;
    logic [7:0] bytes;
    logic [TW-1:0] timer;
    logic sclk;
    logic fsel;
    logic sdi;
    logic [1:0] so;
    logic [2:0] rbit;
    logic [7:0] rsh;
    logic [1:0][7:0] fq;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } shpt_hos_t;

  shpt_hos_t s;
  shpt_hos_t next_s;
  logic half;
  logic pop;
  logic push;
  logic [7:0] rx_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider tick and receive buffer handshake.

  assign half = (s.timer == TW'(SCLK_HALF - 1));
  assign pop = RX_VALID && RX_READY;
  assign rx_byte = {s.rsh[6:0], s.so[1]};
  assign push = (s.st == HS_RX) && half && s.sclk && (s.rbit == 3'h7);

  // Sequencer plus the two-entry receive buffer.
  always_comb begin
    next_s = s;
    next_s.so = {s.so[0], LINK.sdo};
    next_s.timer = s.timer + TW'(1);
    case (s.st)
      HS_IDLE: begin
        next_s.timer = '0;
        if (CMD_VALID) begin
          next_s.st = HS_SETUP;
          next_s.fsel = 1'b1;
          next_s.kind = CMD_KIND;
          next_s.dc = {CMD_DIRECT_COMMAND_INDEX, CMD_DIRECT_COMMAND_PARAMETER};
          next_s.bits = 5'h00;
          next_s.bytes = 8'h00;
          next_s.rbit = 3'h0;
          next_s.nbytes = (CMD_NBYTES == 8'h00) ? 8'h01 : CMD_NBYTES;
          next_s.resp = 1'b0;
          // Words go out most significant bit first.
          case (CMD_KIND)
            KIND_READ: begin
              next_s.tx = {READ_PFX, CMD_ADDR, 8'h00};
              next_s.nbits = READ_BITS;
              next_s.resp = 1'b1;
            end
            KIND_WRITE: begin
              next_s.tx = {WRITE_PFX, CMD_ADDR, CMD_WDATA};
              next_s.nbits = WRITE_BITS;
            end
            default: begin
              next_s.tx = {DIRECT_PFX, CMD_DIRECT_COMMAND_INDEX,
                           CMD_DIRECT_COMMAND_PARAMETER, 16'h0000};
              next_s.nbits = DIRECT_BITS;
              next_s.resp = (CMD_DIRECT_COMMAND_INDEX == DC_HWID) ||
                            (CMD_DIRECT_COMMAND_INDEX == DC_MEAS);
            end
          endcase
        end
      end
      HS_SETUP: begin
        next_s.sdi = s.tx[23];
        if (s.timer == TW'((s.lock ? SC_WARM_CYC : SETUP_COLD_CYC) - 1)) begin
          next_s.st = HS_SHIFT;
          next_s.timer = '0;
        end
      end
      HS_SHIFT: begin
        if (half) begin
          next_s.timer = '0;
          next_s.sclk = ~s.sclk;
          if (s.sclk) begin
            next_s.tx = {s.tx[22:0], 1'b0};
            next_s.sdi = s.tx[22];
            next_s.bits = s.bits + 5'h01;
            if (s.bits + 5'h01 == s.nbits) begin
              next_s.st = s.resp ? HS_GAP : HS_TAIL;
            end
          end
        end
      end
      HS_GAP: begin
        // A measurement may be clocked as soon as its ready shows.
        if (s.so[1] && (s.dc[5:3] == DC_MEAS || s.kind != KIND_DIRECT ||
                        s.timer >= TW'(RS_CYC - 1)) &&
            (s.timer >= TW'(RS_CYC - 1) || s.dc[5:3] == DC_MEAS)) begin
          next_s.st = HS_RX;
          next_s.timer = '0;
        end
      end
      HS_RX: begin
        if (half) begin
          next_s.timer = '0;
          if (!s.sclk) begin
            // Stall between bytes while the buffer cannot take one more.
            if (s.rbit == 3'h0 && s.cnt == 2'h2) begin
              next_s.timer = s.timer;
            end else begin
              next_s.sclk = 1'b1;
            end
          end else begin
            next_s.sclk = 1'b0;
            next_s.rsh = rx_byte;
            next_s.rbit = s.rbit + 3'h1;
            if (s.rbit == 3'h7) begin
              next_s.bytes = s.bytes + 8'h01;
              if (s.bytes + 8'h01 == s.nbytes) begin
                next_s.st = HS_TAIL;
              end
            end
          end
        end
      end
      HS_TAIL: begin
        if (s.timer == TW'((s.kind == KIND_WRITE ? WE_CYC : RE_CYC) - 1)) begin
          next_s.fsel = 1'b0;
          next_s.timer = '0;
          next_s.st = (s.kind == KIND_WRITE) ? HS_WWAIT : HS_IDLE;
          if (s.kind == KIND_DIRECT && s.dc[5:3] == DC_IOMODE) begin
            next_s.lock = (s.dc[2:0] == IOM_SERIAL);
          end
          if (s.kind == KIND_DIRECT && s.dc[5:3] == DC_RESET) begin
            next_s.lock = 1'b0;
          end
        end
      end
      HS_WWAIT: begin
        // The longest write time passes before anything else is sent.
        if (s.timer == TW'(WRITE_WAIT_CYC - 1)) begin
          next_s.st = HS_IDLE;
        end
      end
      default: next_s.st = HS_IDLE;
    endcase
    if (push) begin
      next_s.fq[s.wp] = rx_byte;
      next_s.wp = ~s.wp;
    end
    if (pop) begin
      next_s.rp = ~s.rp;
    end
    next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
  end

  // Synchronous reset; the link starts idle and unlocked.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign LINK.fsel = s.fsel;
  assign LINK.sclk = s.sclk;
  assign LINK.sdi = s.sdi;
  assign CMD_READY = (s.st == HS_IDLE);
  assign RX_VALID = (s.cnt != 2'h0);
  assign RX_DATA = s.fq[s.rp];
  assign BUSY = (s.st != HS_IDLE);

endmodule : shpt_host
`default_nettype wire

// [shpt_link_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the four link wires between the two ends, sampled on the common clock.
module shpt_link_checker
  import shpt_pkg::*;
#(
  parameter int WRITE_CYC = WRITE_CYC_DEF,
  parameter int MEAS_CYC = MEAS_CYC_DEF
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic fsel,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo
);
  localparam int RR_LIM = RR_MAX_CYC;
  localparam int WS_LIM = WS_MAX_CYC;
  localparam int MT_LIM = MEAS_CYC;
  logic sclk_q;
  logic fsel_q;
  logic [15:0] cnt;
  logic [23:0] sh;
  logic rd;
  logic lock;
  logic wr_act;
  int wcnt;
  int gap;
  int setup;
  logic rise;
  logic fall;
  logic fend;
  logic is_rd;
  logic is_wr;
  logic is_dir;
  ////////////////////////////////////////////////////////////////////////////////
  // Edge finders and command decode from the bits shifted in so far.
  assign rise = sclk && !sclk_q;
  assign fall = !sclk && sclk_q;
  assign fend = fsel_q && !fsel;
  assign is_rd = (cnt == 16'h0010) && (sh[15:11] == READ_PFX);
  assign is_wr = (cnt == 16'h0018) && (sh[23:19] == WRITE_PFX);
  assign is_dir = (cnt == 16'h0008) && (sh[7:6] == DIRECT_PFX);
  // Frame tracking; the lock copy lets the end-of-write level be judged without a port.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sclk_q <= 1'b0;
      fsel_q <= 1'b0;
      cnt <= 16'h0000;
      sh <= 24'h000000;
      rd <= 1'b0;
      lock <= 1'b0;
      wr_act <= 1'b0;
      wcnt <= 0;
      gap <= 0;
      setup <= 0;
    end else begin
      sclk_q <= sclk;
      fsel_q <= fsel;
      cnt <= !fsel ? 16'h0000 : (rise ? cnt + 16'h0001 : cnt);
      sh <= rise ? {sh[22:0], sdi} : sh;
      rd <= fsel && (rd || (fall && is_rd));
      gap <= fall ? 0 : gap + 1;
      setup <= fsel ? setup + 1 : 0;
      wcnt <= (fend && is_wr) ? 0 : wcnt + 1;
      wr_act <= (fend && is_wr) || (wr_act && wcnt < WRITE_CYC + 20);
      if (fend && is_dir && sh[5:3] == DC_IOMODE) lock <= (sh[2:0] == IOM_SERIAL);
      else if (fend && is_dir && sh[5:3] == DC_RESET) lock <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // The serial clock must rest low outside frames and respect the setup time.
  chk_idle_clock: assert property (!fsel |-> !sclk) else $error("clock active outside frame");
  chk_setup_time: assert property (rise && fsel |-> setup >= SC_WARM_CYC)
    else $error("first clock too soon after frame select");
  chk_frame_gap: assert property (fend |-> gap >= WE_CYC - 1)
    else $error("frame closed too soon after last clock fall");
  // Every command opens with a one in its second bit when sent most significant bit first.
  chk_second_bit: assert property (rise && cnt == 16'h0001 |-> sdi)
    else $error("command prefix out of order");
  chk_read_ready: assert property (fall && is_rd |-> ##[0:RR_LIM] sdo)
    else $error("read ready late");
  chk_data_wait: assert property (rise && rd && cnt == 16'h0010 |-> sdo && gap >= RS_CYC - 1)
    else $error("data clock before ready");
  chk_data_stable: assert property (fall && rd |-> $stable(sdo))
    else $error("data bit moving at clock fall");
  chk_write_start: assert property (fend && is_wr |-> ##[1:WS_LIM] sdo)
    else $error("write start late");
  chk_write_pulse: assert property (wr_act && wcnt >= 12 && wcnt < WRITE_CYC - 2 |-> sdo)
    else $error("write pulse ended early");
  chk_write_end: assert property (wr_act && lock && wcnt == WRITE_CYC + 16 |-> !sdo)
    else $error("write pulse not ended");
  chk_meas_done: assert property (fall && is_dir && sh[5:3] == DC_MEAS |->
    ##1 !sdo ##[1:MT_LIM] sdo) else $error("measurement done late");
  cov_read: cover property (fall && is_rd);
  cov_write: cover property (fend && is_wr && lock);
  cov_meas: cover property (fall && is_dir && sh[5:3] == DC_MEAS);
endmodule : shpt_link_checker
`default_nettype wire

// [serial_host_port_timing_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Joins both ends over one link and compares the host's user side with a model.
module serial_host_port_timing_tb_top
  import shpt_pkg::*;
;
  localparam logic [7:0] HWID = 8'h3C; // Arbitrary identifier value.
  // Shortened timings keep the run short; the write wait still covers the write.
  localparam int WR_CYC = 300;
  localparam int MS_CYC = 200;
  localparam int SU_CYC = 150;
  localparam int WW_CYC = 400;
  logic mclk, reset, cmd_valid, cmd_ready, rx_valid, rx_ready, busy;
  logic aux_level, serial_locked, write_busy, stall, wb_seen;
  logic [1:0] cmd_kind;
  logic [10:0] cmd_addr, a;
  logic [7:0] cmd_wdata, cmd_nbytes, rx_data;
  logic [2:0] cmd_dir_index, cmd_dir_param;
  logic [15:0] meas_value;
  logic [31:0] lfsr, rdy_s;
  logic [7:0] mem [0:2047];
  logic [7:0] rx_q [$];
  int err_count, checks_done;
  shpt_link_if shpt_link_if_i ();
  shpt_device #(.WRITE_CYC(WR_CYC), .MEAS_CYC(MS_CYC), .HW_ID(HWID)) shpt_device_i (.MCLK(mclk),
    .RESET(reset), .LINK(shpt_link_if_i.dev), .AUX_LEVEL(aux_level), .MEAS_VALUE(meas_value),
    .SERIAL_LOCKED(serial_locked), .WRITE_BUSY(write_busy));
  shpt_host #(.SETUP_COLD_CYC(SU_CYC), .WRITE_WAIT_CYC(WW_CYC)) shpt_host_i (.MCLK(mclk),
    .RESET(reset), .LINK(shpt_link_if_i.host), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_KIND(cmd_kind), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
    .CMD_DIRECT_COMMAND_INDEX(cmd_dir_index), .CMD_DIRECT_COMMAND_PARAMETER(cmd_dir_param),
    .CMD_NBYTES(cmd_nbytes), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .RX_DATA(rx_data), .BUSY(busy));
  shpt_link_checker #(.WRITE_CYC(WR_CYC), .MEAS_CYC(MS_CYC)) shpt_link_checker_i (.MCLK(mclk),
    .RESET(reset), .fsel(shpt_link_if_i.fsel), .sclk(shpt_link_if_i.sclk),
    .sdi(shpt_link_if_i.sdi), .sdo(shpt_link_if_i.sdo));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic conclude();
    $display("counts: %0d checks, %0d mismatches", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // One command through the host; returns once the host is idle again.
  task automatic run_cmd(input logic [1:0] k, input logic [10:0] ad, input logic [7:0] wd,
      input logic [2:0] dc, input logic [2:0] dp, input logic [7:0] nb);
    int n;
    rx_q.delete();
    @(negedge mclk);
    {cmd_kind, cmd_addr, cmd_wdata, cmd_dir_index, cmd_dir_param, cmd_nbytes} =
      {k, ad, wd, dc, dp, nb};
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 30000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 30000) check(1'b0, 1'b1, "command never finished");
  endtask : run_cmd
  // Reads four bytes from 7FE across the address wrap and compares them with the model.
  task automatic read_back();
    run_cmd(KIND_READ, 11'h7FE, 8'h00, 3'h0, 3'h0, 8'h04);
    check(16'(rx_q.size()), 16'h0004, "byte count");
    for (int i = 0; i < 4 && i < rx_q.size(); i++) begin
      a = 11'h7FE + 11'(i);
      check({8'h00, rx_q[i]}, {8'h00, mem[a]}, "read byte");
    end
  endtask : read_back
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Received bytes are queued as the host hands them over.
  always @(posedge mclk) if (rx_valid === 1'b1 && rx_ready === 1'b1) rx_q.push_back(rx_data);
  always @(posedge mclk) if (write_busy === 1'b1) wb_seen <= 1'b1;
  // Random receiver stalls exercise the two-entry buffer on every read.
  always @(negedge mclk) begin
    rdy_s <= lfsr_next(rdy_s);
    rx_ready <= !stall && rdy_s[0];
  end
  // A hang anywhere ends the run as a mismatch; normal runs need about 11500 cycles.
  initial begin
    repeat (80000) @(posedge mclk);
    check(1'b0, 1'b1, "watchdog expired");
    conclude();
  end
  initial begin
    {reset, cmd_valid, rx_ready, stall, aux_level, wb_seen} = 6'h20;
    {cmd_kind, cmd_addr, cmd_wdata, cmd_dir_index, cmd_dir_param, cmd_nbytes, meas_value} = '0;
    lfsr = 32'hD015;
    rdy_s = 32'hD015;
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    check(cmd_ready, 1'b1, "idle after reset");
    run_cmd(KIND_DIRECT, 11'h000, 8'h00, DC_IOMODE, IOM_SERIAL, 8'h01);
    check(serial_locked, 1'b1, "serial lock");
    $display("test lock done");
    // Writes cross the address wrap so the read below wraps too.
    for (int i = 0; i < 4; i++) begin
      a = 11'h7FE + 11'(i);
      lfsr = lfsr_next(lfsr);
      mem[a] = lfsr[7:0];
      wb_seen = 1'b0;
      run_cmd(KIND_WRITE, a, lfsr[7:0], 3'h0, 3'h0, 8'h01);
      check(wb_seen, 1'b1, "write busy shown");
      check(shpt_link_if_i.sdo, 1'b0, "line low after write");
    end
    $display("test write done");
    read_back();
    $display("test read done");
    stall = 1'b1;
    fork
      read_back();
      begin
        repeat (3000) @(negedge mclk);
        check(rx_valid, 1'b1, "buffer held while stalled");
        check(shpt_link_if_i.sclk, 1'b0, "clock parked while full");
        check(busy, 1'b1, "host busy while stalled");
        stall = 1'b0;
      end
    join
    $display("test stall done");
    run_cmd(KIND_DIRECT, 11'h000, 8'h00, DC_HWID, 3'h0, 8'h01);
    check({8'h00, rx_q[0]}, {8'h00, HWID}, "identifier byte");
    run_cmd(KIND_DIRECT, 11'h000, 8'h00, DC_RESET, 3'h0, 8'h01);
    check(serial_locked, 1'b0, "lock cleared");
    $display("test direct done");
    lfsr = lfsr_next(lfsr);
    aux_level = lfsr[9];
    run_cmd(KIND_WRITE, 11'h010, lfsr[7:0], 3'h0, 3'h0, 8'h01);
    check(shpt_link_if_i.sdo, aux_level, "line back to its other use");
    $display("test unlocked write done");
    meas_value = lfsr[31:16];
    run_cmd(KIND_DIRECT, 11'h000, 8'h00, DC_MEAS, 3'h0, 8'h02);
    check(16'(rx_q.size()), 16'h0002, "result byte count");
    check({rx_q[0], rx_q[1]}, meas_value, "measurement result");
    $display("test measure done");
    conclude();
  end
endmodule : serial_host_port_timing_tb_top
`default_nettype wire
